//--- hw/lss_pkg.sv
// Constants and types shared by the LED sink shift/latch block.
// Assumes a 32-bit classic Wishbone slave with byte addresses.

`default_nettype none

package lss_pkg;

    // ------------------------------------------------------------
    // Structure
    // ------------------------------------------------------------
    localparam int LSS_CHANNELS = 8;
    localparam int LSS_FIFO_DEPTH = 2;
    localparam int LSS_ADR_W = 8;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] LSS_ADR_CTRL = 8'h00;
    localparam logic [7:0] LSS_ADR_STATUS = 8'h04;
    localparam logic [7:0] LSS_ADR_SHIFT = 8'h08;
    localparam logic [7:0] LSS_ADR_DISPLAY = 8'h0C;
    localparam logic [7:0] LSS_ADR_OPEN = 8'h10;
    localparam logic [7:0] LSS_ADR_SHORT = 8'h14;
    localparam logic [7:0] LSS_ADR_TEMP = 8'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LSS_CTRL_MODE_LSB = 0;
    localparam int LSS_CTRL_HOLD_BIT = 2;
    localparam int LSS_CTRL_CLR_OVR_BIT = 3;
    localparam int LSS_STAT_MODE_LSB = 0;
    localparam int LSS_STAT_STEP_LSB = 4;
    localparam int LSS_STAT_GFAULT_BIT = 8;
    localparam int LSS_STAT_COUNT_LSB = 12;
    localparam int LSS_STAT_OVR_BIT = 16;
    localparam int LSS_STAT_READY_BIT = 17;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0] LSS_MODE_RST = 2'h0;
    localparam logic LSS_HOLD_RST = 1'b0;
    localparam logic LSS_SDO_RST = 1'b1;
    localparam logic [31:0] LSS_RDATA_UNMAPPED = 32'h0000_0000;

    // ------------------------------------------------------------
    // Modes and diagnostic steps
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LSS_MODE_NORMAL,
        LSS_MODE_GLOBAL,
        LSS_MODE_DETAIL,
        LSS_MODE_LOWI
    } lss_mode_e;

    typedef enum logic [1:0] {
        LSS_STEP_TEMP,
        LSS_STEP_OPEN,
        LSS_STEP_SHORT
    } lss_step_e;

endpackage : lss_pkg

`default_nettype wire

//--- hw/lss_shift_latch.sv
// Shift register, load buffer and display latch of an eight-channel
// LED sink driver, with fault read-back and a Wishbone register port.
// Assumes all pins are asynchronous to clk_i and are synchronised here;
// the serial clock must be well below clk_i / 4 to be edge-detected.
//
// Added by the designer: the Wishbone slave port and the register addresses.

`default_nettype none

module lss_shift_latch
    import lss_pkg::*;
#(
    parameter int CHANNELS = LSS_CHANNELS,
    parameter int FIFO_DEPTH = LSS_FIFO_DEPTH
)(
    input wire logic clk_i, // System clock, 20 MHz
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic ce_i, // Clock enable, freezes state when low
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [LSS_ADR_W-1:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    input wire logic [31:0] wb_dat_i, // Wishbone write data
    output logic [31:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    input wire logic serial_clk_i, // Serial clock pin
    input wire logic serial_in_pin_i, // Serial data pin
    input wire logic load_strobe_i, // Load strobe pin
    input wire logic sink_enable_low_n_i, // Sink enable pin, low active
    input wire logic overtemp_i, // Thermal sensor flag
    input wire logic [CHANNELS-1:0] sink_channels_in_i, // Pin sense
    output logic [CHANNELS-1:0] sink_channels_out_o, // Pin drive level
    output logic [CHANNELS-1:0] sink_channels_oe_o, // Pin sinking
    output logic low_current_o, // Reduced test current
    output logic serial_out_pin_o, // Serial output pin
    output logic load_ready_o // Load buffer has room
);

    localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int SYNC_W = 4 + CHANNELS;

    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic sclk_q_reg;
    logic ld_q_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sclk_q_reg <= 1'b0;
            ld_q_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            sync1_reg <= {serial_clk_i, serial_in_pin_i, load_strobe_i,
                          overtemp_i, sink_channels_in_i};
            sync2_reg <= sync1_reg;
            sclk_q_reg <= sync2_reg[SYNC_W-1];
            ld_q_reg <= sync2_reg[SYNC_W-3];
        end
    end

    // The enable pin is kept apart so reset can leave it "disabled"
    logic oen_s1_reg;
    logic oen_s_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            oen_s1_reg <= 1'b1;
            oen_s_reg <= 1'b1;
        end
        else if (ce_i)
        begin
            oen_s1_reg <= sink_enable_low_n_i;
            oen_s_reg <= oen_s1_reg;
        end
    end

    wire sclk_s = sync2_reg[SYNC_W-1];
    wire sdi_s = sync2_reg[SYNC_W-2];
    wire ld_s = sync2_reg[SYNC_W-3];
    wire otemp_s = sync2_reg[SYNC_W-4];
    wire [CHANNELS-1:0] sense_s = sync2_reg[CHANNELS-1:0];
    wire sclk_rise = sclk_s & ~sclk_q_reg;
    wire sclk_fall = ~sclk_s & sclk_q_reg;
    wire ld_rise = ld_s & ~ld_q_reg;

    // ------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------
    logic [1:0] mode_reg;
    logic hold_reg;
    logic overrun_reg;
    lss_step_e step_reg;
    lss_step_e step_next;

    wire lss_mode_e mode = lss_mode_e'(mode_reg);
    wire err_mode = (mode != LSS_MODE_NORMAL);

    always_comb
    begin
        case (step_reg)
            LSS_STEP_TEMP: step_next = LSS_STEP_OPEN;
            LSS_STEP_OPEN: step_next = LSS_STEP_SHORT;
            LSS_STEP_SHORT: step_next = LSS_STEP_TEMP;
            default: step_next = LSS_STEP_TEMP;
        endcase
    end

    // ------------------------------------------------------------
    // Shift register and serial output
    // ------------------------------------------------------------
    logic [CHANNELS-1:0] shift_reg;
    logic sdo_reg;

    // Detail read-back: a load in detail mode puts the current test
    // step's results into the shift register for clocking out.
    logic [CHANNELS-1:0] open_res_reg;
    logic [CHANNELS-1:0] short_res_reg;
    logic temp_res_reg;
    logic [CHANNELS-1:0] detail_word;

    always_comb
    begin
        case (step_reg)
            LSS_STEP_OPEN: detail_word = open_res_reg;
            LSS_STEP_SHORT: detail_word = short_res_reg;
            default: detail_word = {CHANNELS{temp_res_reg}};
        endcase
    end

    wire detail_load = ld_rise & (mode == LSS_MODE_DETAIL);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            shift_reg <= '0;
        else if (ce_i)
        begin
            if (detail_load)
                shift_reg <= detail_word;
            else if (sclk_rise)
                shift_reg <= {shift_reg[CHANNELS-2:0], sdi_s};
        end
    end

    logic gfault_reg;

    // Data leaves on the falling edge after eight rising edges, which
    // gives the half-cycle offset a cascade relies on.
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            sdo_reg <= LSS_SDO_RST;
        else if (ce_i)
        begin
            if (mode == LSS_MODE_GLOBAL)
                sdo_reg <= ~gfault_reg;
            else if (sclk_fall)
                sdo_reg <= shift_reg[CHANNELS-1];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            step_reg <= LSS_STEP_TEMP;
        else if (ce_i)
        begin
            if (!err_mode)
                step_reg <= LSS_STEP_TEMP;
            else if (sclk_rise)
                step_reg <= step_next;
        end
    end

    // ------------------------------------------------------------
    // Load buffer between shift register and display
    // ------------------------------------------------------------
    logic [CHANNELS-1:0] fifo_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] count_reg;
    logic [CHANNELS-1:0] display_reg;

    wire fifo_full = (count_reg == CNT_W'(FIFO_DEPTH));
    wire fifo_empty = (count_reg == '0);
    wire push = ld_rise & ~fifo_full;
    wire pop = ~fifo_empty & ~hold_reg;
    wire overrun_set = ld_rise & fifo_full;
    wire [PTR_W-1:0] wr_ptr_next = (wr_ptr_reg == PTR_W'(FIFO_DEPTH - 1))
                                   ? '0 : wr_ptr_reg + 1'b1;
    wire [PTR_W-1:0] rd_ptr_next = (rd_ptr_reg == PTR_W'(FIFO_DEPTH - 1))
                                   ? '0 : rd_ptr_reg + 1'b1;

    always_ff @(posedge clk_i)
    begin
        if (ce_i && push)
            fifo_mem[wr_ptr_reg] <= shift_reg;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end
        else if (ce_i)
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_next;
            if (pop)
                rd_ptr_reg <= rd_ptr_next;
            if (push && !pop)
                count_reg <= count_reg + 1'b1;
            else if (pop && !push)
                count_reg <= count_reg - 1'b1;
        end
    end

    // Further shifting never reaches the sinks, only a pop does
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            display_reg <= '0;
        else if (ce_i && pop)
            display_reg <= fifo_mem[rd_ptr_reg];
    end

    // ------------------------------------------------------------
    // Fault detection
    // ------------------------------------------------------------
    // An open LED cannot pull a sinking pin up; a shorted LED
    // leaves it high. Results gather until a load in normal mode; set beats clear.
    wire [CHANNELS-1:0] drive_on = display_reg & {CHANNELS{~oen_s_reg}};
    wire [CHANNELS-1:0] open_now = (err_mode && step_reg == LSS_STEP_OPEN)
                                   ? (drive_on & ~sense_s) : '0;
    wire [CHANNELS-1:0] short_now = (err_mode && step_reg == LSS_STEP_SHORT)
                                    ? (drive_on & sense_s) : '0;
    wire temp_now = err_mode & otemp_s;
    wire any_fault = (|open_res_reg) | (|short_res_reg) | temp_res_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            open_res_reg <= '0;
            short_res_reg <= '0;
            temp_res_reg <= 1'b0;
            gfault_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            open_res_reg <= open_now | open_res_reg;
            short_res_reg <= short_now | short_res_reg;
            temp_res_reg <= temp_now | temp_res_reg;
            if (ld_rise && err_mode)
                gfault_reg <= any_fault | (|open_now) | (|short_now)
                              | temp_now;
            if (ld_rise && !err_mode)
            begin
                open_res_reg <= open_now;
                short_res_reg <= short_now;
                temp_res_reg <= temp_now;
            end
        end
    end

    // ------------------------------------------------------------
    // Sink pins
    // ------------------------------------------------------------
    // Pins are open drain: the level is always low, only the enable
    // moves. In diagnostic modes the pins are also read as senses.
    logic [CHANNELS-1:0] oe_reg;
    logic [CHANNELS-1:0] out_reg;
    logic lowi_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            oe_reg <= '0;
            out_reg <= '0;
            lowi_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            oe_reg <= drive_on;
            out_reg <= '0;
            lowi_reg <= (mode == LSS_MODE_LOWI);
        end
    end

    // ------------------------------------------------------------
    // Wishbone slave
    // ------------------------------------------------------------
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic ready_reg;

    wire req = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire wr_ctrl = req & wb_we_i & wb_sel_i[0]
                   & (wb_adr_i == LSS_ADR_CTRL);
    wire ovr_clear = wr_ctrl & wb_dat_i[LSS_CTRL_CLR_OVR_BIT];

    wire [31:0] ctrl_word = 32'({hold_reg, mode_reg});
    wire [31:0] stat_word =
        (32'(mode_reg) << LSS_STAT_MODE_LSB)
        | (32'(step_reg) << LSS_STAT_STEP_LSB)
        | (32'(gfault_reg) << LSS_STAT_GFAULT_BIT)
        | (32'(count_reg) << LSS_STAT_COUNT_LSB)
        | (32'(overrun_reg) << LSS_STAT_OVR_BIT)
        | (32'(ready_reg) << LSS_STAT_READY_BIT);
    wire [31:0] rdata_mux =
        (wb_adr_i == LSS_ADR_CTRL) ? ctrl_word :
        (wb_adr_i == LSS_ADR_STATUS) ? stat_word :
        (wb_adr_i == LSS_ADR_SHIFT) ? 32'(shift_reg) :
        (wb_adr_i == LSS_ADR_DISPLAY) ? 32'(display_reg) :
        (wb_adr_i == LSS_ADR_OPEN) ? 32'(open_res_reg) :
        (wb_adr_i == LSS_ADR_SHORT) ? 32'(short_res_reg) :
        (wb_adr_i == LSS_ADR_TEMP) ? 32'(temp_res_reg) :
        LSS_RDATA_UNMAPPED;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            rdata_reg <= '0;
            mode_reg <= LSS_MODE_RST;
            hold_reg <= LSS_HOLD_RST;
        end
        else if (ce_i)
        begin
            ack_reg <= req;
            if (req)
                rdata_reg <= wb_we_i ? '0 : rdata_mux;
            if (wr_ctrl)
            begin
                mode_reg <= wb_dat_i[LSS_CTRL_MODE_LSB +: 2];
                hold_reg <= wb_dat_i[LSS_CTRL_HOLD_BIT];
            end
        end
    end

    // A lost load is reported, and a new overrun wins over the clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            overrun_reg <= 1'b0;
            ready_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            overrun_reg <= overrun_set | (overrun_reg & ~ovr_clear);
            ready_reg <= ~fifo_full | pop;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign sink_channels_oe_o = oe_reg;
    assign sink_channels_out_o = out_reg;
    assign low_current_o = lowi_reg;
    assign serial_out_pin_o = sdo_reg;
    assign load_ready_o = ready_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_shift_capture: assert property (
        ce_i && sclk_rise && !detail_load
        |=> shift_reg == {$past(shift_reg[CHANNELS-2:0]), $past(sdi_s)})
        else $error("shift register missed a serial bit");

    chk_sdo_advance: assert property (
        ce_i && sclk_fall && mode != LSS_MODE_GLOBAL
        |=> serial_out_pin_o == $past(shift_reg[CHANNELS-1]))
        else $error("serial output did not advance on falling edge");

    chk_sdo_steady: assert property (
        ce_i && !sclk_fall && mode != LSS_MODE_GLOBAL
        |=> $stable(serial_out_pin_o))
        else $error("serial output moved without a falling edge");

    chk_err_stepping: assert property (
        ce_i && err_mode && sclk_rise
        |=> step_reg == $past(step_next))
        else $error("error mode did not step on rising edge");

    chk_load_push: assert property (
        ce_i && ld_rise && !fifo_full && hold_reg
        |=> count_reg == $past(count_reg) + 1'b1)
        else $error("load strobe did not enter the buffer");

    chk_display_hold: assert property (
        ce_i && !pop |=> $stable(display_reg))
        else $error("display changed without a load");

    chk_enable_gate: assert property (
        ce_i && oen_s_reg |=> sink_channels_oe_o == '0)
        else $error("sinks active while enable pin high");

    chk_global_sdo: assert property (
        ce_i && mode == LSS_MODE_GLOBAL
        |=> serial_out_pin_o == !$past(gfault_reg))
        else $error("global fault not shown on serial output");

    chk_fault_latch: assert property (
        ce_i && ld_rise && err_mode && (|open_now)
        |=> gfault_reg)
        else $error("fault not latched at load");

    chk_low_current: assert property (
        ce_i ##1 ce_i |-> low_current_o
        == ($past(mode_reg) == LSS_MODE_LOWI))
        else $error("low current flag wrong for mode");

    chk_sense_open: assert property (
        ce_i && (|open_now) |=> |open_res_reg)
        else $error("sensed open channel not recorded");

endmodule : lss_shift_latch

`default_nettype wire

//--- bench/lss_host_model.sv
// Behavioural host controller for the serial shift/load pins.
// Assumes the bench calls one task at a time; the link clock idles low.

`default_nettype none

module lss_host_model (
    input wire logic serial_out_pin_i, // Spill from the block
    output logic serial_clk_o, // Serial clock, idle low
    output logic serial_in_pin_o, // Serial data
    output logic load_strobe_o // Load strobe
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        serial_clk_o = 1'b0;
        serial_in_pin_o = 1'b0;
        load_strobe_o = 1'b0;
    end

    // ------------------------------------------------------------
    // Frames
    // ------------------------------------------------------------
    // Sends n bits MSB first; spill gets the output as it stands just
    // before each rising edge, which is what a chained device would take
    task automatic shift(input logic [15:0] d, input int n,
                         output logic [7:0] spill);
        #13; // Keeps the link out of phase with the system clock
        for (int i = n - 1; i >= 0; i--)
        begin
            serial_in_pin_o = d[i];
            #200;
            spill = {spill[6:0], serial_out_pin_i};
            serial_clk_o = 1'b1;
            #200;
            serial_clk_o = 1'b0;
        end
        #200;
        // A released data line must not keep showing the last bit
        serial_in_pin_o = ~serial_in_pin_o;
    endtask : shift

    // Strobe only once shifting is over and the last edge has settled
    task automatic load();
        #400;
        load_strobe_o = 1'b1;
        #400;
        load_strobe_o = 1'b0;
        #400;
    endtask : load

endmodule : lss_host_model

`default_nettype wire

//--- bench/lss_shift_latch_tb.sv
// Self-checking bench for the LED sink shift/latch block.
// Assumes the host model drives the serial pins, this module the rest.

`default_nettype none

module lss_shift_latch_tb
    import lss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed
    {
        logic [7:0] data;
        logic en_n;
        logic [7:0] oe;
        logic [7:0] prev;
    } lss_row_s;

    localparam lss_row_s ROWS [4] = '{'{8'hA5, 1'b0, 8'hA5, 8'h3C},
        '{8'h5A, 1'b0, 8'h5A, 8'hA5}, '{8'hFF, 1'b1, 8'h00, 8'h5A},
        '{8'h81, 1'b0, 8'h81, 8'hFF}};
    localparam logic [7:0] FILL [3] = '{8'h11, 8'h22, 8'h33};

    logic clk_i, rst_i, ce_i, wb_cyc, wb_stb, wb_we, wb_ack_o;
    logic en_n, overtemp, serial_clk, serial_in, load_strobe;
    logic serial_out, low_current, load_ready;
    logic [7:0] wb_adr, sense, oe, sink_out, spill;
    logic [3:0] wb_sel;
    logic [31:0] wb_wdat, wb_dat_o, rd;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;

    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    lss_shift_latch i_lss_shift_latch (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .serial_clk_i(serial_clk),
        .serial_in_pin_i(serial_in), .load_strobe_i(load_strobe),
        .sink_enable_low_n_i(en_n), .overtemp_i(overtemp),
        .sink_channels_in_i(sense), .sink_channels_out_o(sink_out),
        .sink_channels_oe_o(oe), .low_current_o(low_current),
        .serial_out_pin_o(serial_out), .load_ready_o(load_ready));

    lss_host_model i_lss_host_model (
        .serial_out_pin_i(serial_out), .serial_clk_o(serial_clk),
        .serial_in_pin_o(serial_in), .load_strobe_o(load_strobe));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        if (mismatches == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test

    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] wd, output logic [31:0] rdat);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_sel <= 4'hF;
        wb_adr <= adr;
        wb_wdat <= wd;
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb

    task automatic reset_dut();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (16) @(posedge clk_i);
        check({12'h0, wb_ack_o, oe, sink_out, low_current, serial_out,
               load_ready}, 32'h2);
        check(wb_dat_o, 32'h0);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check({31'h0, load_ready}, 32'h1);
    endtask : reset_dut

    // A hang counts as a mismatch and closes the run
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 10000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial
    begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_sel = 4'h0;
        wb_adr = 8'h00;
        wb_wdat = 32'h0;
        en_n = 1'b1;
        overtemp = 1'b0;
        sense = 8'hFF;
        reset_dut();
        i_lss_host_model.shift(16'h003C, 8, spill);
        foreach (ROWS[i])
        begin
            @(posedge clk_i);
            en_n <= ROWS[i].en_n;
            i_lss_host_model.shift({8'h00, ROWS[i].data}, 8, spill);
            check({24'h0, spill}, {24'h0, ROWS[i].prev});
            i_lss_host_model.load();
            check({24'h0, oe}, {24'h0, ROWS[i].oe});
            wb(1'b0, LSS_ADR_DISPLAY, 32'h0, rd);
            check(rd, {24'h0, ROWS[i].data});
        end
        i_lss_host_model.shift(16'h003C, 8, spill);
        check({24'h0, oe}, 32'h81);
        wb(1'b0, LSS_ADR_SHIFT, 32'h0, rd);
        check(rd, 32'h3C);
        wb(1'b1, LSS_ADR_DISPLAY, 32'hFF, rd);
        wb(1'b0, LSS_ADR_DISPLAY, 32'h0, rd);
        check(rd, 32'h81);
        wb(1'b0, 8'h40, 32'h0, rd);
        check(rd, LSS_RDATA_UNMAPPED);
        @(posedge clk_i);
        en_n <= 1'b1;
        for (int m = 0; m < 4; m++)
        begin
            wb(1'b1, LSS_ADR_CTRL, 32'(m), rd);
            wb(1'b0, LSS_ADR_STATUS, 32'h0, rd);
            check({30'h0, rd[1:0]}, 32'(m));
            check({31'h0, low_current}, (m == 3) ? 32'h1 : 32'h0);
            check({24'h0, oe}, 32'h0);
        end
        // Global mode: channel 0 reads high, channel 7 low
        wb(1'b1, LSS_ADR_CTRL, 32'h1, rd);
        @(posedge clk_i);
        en_n <= 1'b0;
        overtemp <= 1'b1;
        sense <= 8'h01;
        wb(1'b0, LSS_ADR_STATUS, 32'h0, rd);
        check({31'h0, serial_out}, 32'h1);
        i_lss_host_model.shift(16'h0081, 8, spill);
        wb(1'b0, LSS_ADR_STATUS, 32'h0, rd);
        check({30'h0, rd[5:4]}, 32'h2);
        i_lss_host_model.load();
        check({31'h0, serial_out}, 32'h0);
        wb(1'b0, LSS_ADR_SHORT, 32'h0, rd);
        check(rd, 32'h01);
        wb(1'b0, LSS_ADR_OPEN, 32'h0, rd);
        check(rd, 32'h80);
        wb(1'b0, LSS_ADR_TEMP, 32'h0, rd);
        check(rd, 32'h1);
        // Detail mode: two edges reach the open step, a load reads it back
        wb(1'b1, LSS_ADR_CTRL, 32'h2, rd);
        i_lss_host_model.shift(16'h0001, 2, spill);
        wb(1'b0, LSS_ADR_STATUS, 32'h0, rd);
        check({30'h0, rd[5:4]}, 32'h1);
        i_lss_host_model.load();
        check({24'h0, oe}, 32'h05);
        wb(1'b0, LSS_ADR_SHIFT, 32'h0, rd);
        check(rd, 32'h80);
        // Hold the drain, fill the buffer, overrun it, then drain
        wb(1'b1, LSS_ADR_CTRL, 32'h4, rd);
        foreach (FILL[i])
        begin
            i_lss_host_model.shift({8'h00, FILL[i]}, 8, spill);
            i_lss_host_model.load();
        end
        check({31'h0, load_ready}, 32'h0);
        check({24'h0, oe}, 32'h05);
        wb(1'b0, LSS_ADR_STATUS, 32'h0, rd);
        check({31'h0, rd[16]}, 32'h1);
        wb(1'b1, LSS_ADR_CTRL, 32'h0, rd);
        wb(1'b0, LSS_ADR_DISPLAY, 32'h0, rd);
        check(rd, 32'h22);
        wb(1'b1, LSS_ADR_CTRL, 32'h8, rd);
        wb(1'b0, LSS_ADR_STATUS, 32'h0, rd);
        check({30'h0, rd[17:16]}, 32'h2);
        reset_dut();
        end_of_test();
    end

endmodule : lss_shift_latch_tb

`default_nettype wire
